// >>> logic/ufa_pkg.sv
// constants, types and register map of the serial receive-enhancement block
// assumes one 10 MHz clock and an AXI4-Lite master with 32-bit data
//
// Notes on behaviour
// - port offers synchronous mode 0 and asynchronous full-duplex modes 1, 2, 3
// - transmitter and receiver run together, each from its own baud divider
// - framing checks act only in modes 1 to 3 and with framing_check_enable set
// - an invalid stop bit sets framing_error_flag while checking is enabled
// - framing_error_flag stays until software clears it or reset; good frames keep it
// - with checking on, receive_done_flag rises at the stop sample, not last data bit
// - address recognition runs in hardware in modes 1 to 3 whenever multiprocessor_enable is set
// - with recognition on, only a command frame with matching address raises the done flag
// - in mode 1 the stop bit stands in for the ninth, command-marking bit
// - mode 1 with recognition: done flag needs a matching address and valid stop bit
// - a frame qualifies on a match with the given or the broadcast address
// - in mode 0 multiprocessor_enable has no effect on reception
// - given address compares slave address under mask; mask zeros are don't-care
// - broadcast address is address OR mask; its zero bits are don't-care
// - reset clears slave address and mask, so every address matches

package ufa_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_SERIAL_CONTROL = 8'h00;
  localparam logic [7:0] A_SERIAL_DATA = 8'h04;
  localparam logic [7:0] A_POWER_CONTROL = 8'h08;
  localparam logic [7:0] A_SLAVE_ADDRESS = 8'h0C;
  localparam logic [7:0] A_SLAVE_ADDRESS_MASK = 8'h10;
  localparam logic [7:0] A_TX_BAUD = 8'h14;
  localparam logic [7:0] A_RX_BAUD = 8'h18;
  localparam logic [7:0] A_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] A_IRQ_MASK = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SC_TOP = 7;
  localparam int SC_MODE1 = 6;
  localparam int SC_MPE = 5;
  localparam int SC_RXEN = 4;
  localparam int SC_TB8 = 3;
  localparam int SC_RB8 = 2;
  localparam int SC_TI = 1;
  localparam int SC_RC = 0;
  localparam int PC_FCE = 6;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_ER = 2;
  localparam int IRQ_W = 3;

  // ----------------------------------------------------------------
  // reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_BAUD = 8'h40;
  localparam logic [7:0] MODE2_DIV = 8'h1F;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] BITS8_LAST = 4'h7;
  localparam logic [3:0] BITS9_LAST = 4'h8;
  localparam logic [3:0] TX0_LAST = 4'h7;
  localparam logic [3:0] TX1_LAST = 4'h9;
  localparam logic [3:0] TX2_LAST = 4'hA;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0,
    MODE_8BIT = 2'h1,
    MODE_9FIX = 2'h2,
    MODE_9VAR = 2'h3
  } ufa_mode_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_START = 2'h1,
    S_DATA = 2'h3,
    S_STOP = 2'h2
  } ufa_state_t;

endpackage

// >>> logic/ufa_baud_tick.sv
// one-cycle tick divider used for the 16x bit rate of each direction
// assumes run is a same-clock level; the phase restarts whenever run drops

`timescale 1ns/1ps
`default_nettype none

module ufa_baud_tick (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic [7:0] reload,
  // tick out
  output logic tick
);
  import ufa_pkg::*;

  logic [7:0] cnt_r;
  logic tick_r;

  // ----------------------------------------------------------------
  // down counter, one tick every reload+1 cycles
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= RST_BYTE;
      tick_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= reload; // restarting keeps the first sample centred
      tick_r <= 1'b0;
    end else if (cnt_r == RST_BYTE) begin
      cnt_r <= reload;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r - 8'h01;
      tick_r <= 1'b0;
    end
  end

  assign tick = tick_r;

endmodule

`default_nettype wire

// >>> logic/ufa_serial_port.sv
// serial port with framing check and automatic address recognition
// assumes an AXI4-Lite master on aclk and an asynchronous receive pin

`timescale 1ns/1ps
`default_nettype none

module ufa_serial_port (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // serial line
  input wire logic rxd_pin,
  output logic txd_pin,
  output logic shift_clk_pin,
  // interrupt
  output logic irq
);
  import ufa_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic aw_ok_r, w_ok_r, bvalid_r, rvalid_r, wlane_r;
  logic [7:0] awaddr_r, wdata_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic wr_go;
  logic [7:0] rd_mux;
  logic rd_hit, wr_hit;
  logic md0_r, md1_r, mpe_r, ren_r, tb8_r, rb8_r, ti_r, rc_r, er_r;
  logic fce_r;
  logic [7:0] sadr_r, smask_r, txdiv_r, rxdiv_r, rxbuf_r;
  logic [IRQ_W-1:0] sts_r, mask_r;
  logic irq_r;
  ufa_mode_t mode;
  logic nine;
  logic rxd_meta_r, rxd_r;
  ufa_state_t rx_st_r, tx_st_r;
  logic [3:0] rx_ovs_r, rx_bit_r, tx_ovs_r, tx_bit_r;
  logic [8:0] rx_sh_r, rx_sh_nxt, rx_src;
  logic [10:0] tx_sh_r;
  logic rx_tick, tx_tick;
  logic [7:0] rx_div, tx_div;
  logic rx_mid_done, rx_early, rx_late, late_mode, rx_decide;
  logic [7:0] rx_word;
  logic rx_cmd, addr_hit, rx_load, er_set, tx_go, tx_done;
  logic [3:0] rx_last_bit, tx_last_bit;
  logic txd_r, sclk_r;

  assign mode = ufa_mode_t'({md0_r, md1_r});
  assign nine = mode[1];

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  // address and data are latched on their own; the write fires once both are in
  assign s_axi_awready = !aw_ok_r && !bvalid_r;
  assign s_axi_wready = !w_ok_r && !bvalid_r;
  assign wr_go = aw_ok_r && w_ok_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r <= 1'b0;
      awaddr_r <= RST_BYTE;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_ok_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_ok_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_ok_r <= 1'b0;
      wdata_r <= RST_BYTE;
      wlane_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_ok_r <= 1'b1;
      wdata_r <= s_axi_wdata[7:0];
      wlane_r <= s_axi_wstrb[0]; // registers are one byte wide
    end else if (wr_go) begin
      w_ok_r <= 1'b0;
    end
  end

  // write response: unmapped offsets answer slverr and change nothing
  always_comb begin
    unique case (awaddr_r)
      A_SERIAL_CONTROL, A_SERIAL_DATA, A_POWER_CONTROL, A_SLAVE_ADDRESS,
      A_SLAVE_ADDRESS_MASK, A_TX_BAUD, A_RX_BAUD, A_IRQ_STATUS,
      A_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // read mux; reads carry no side effects
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      A_SERIAL_CONTROL:
        rd_mux = {fce_r ? er_r : md0_r, md1_r, mpe_r, ren_r,
                  tb8_r, rb8_r, ti_r, rc_r};
      A_SERIAL_DATA: rd_mux = rxbuf_r;
      A_POWER_CONTROL: rd_mux = {1'b0, fce_r, 6'h00};
      A_SLAVE_ADDRESS: rd_mux = sadr_r;
      A_SLAVE_ADDRESS_MASK: rd_mux = smask_r;
      A_TX_BAUD: rd_mux = txdiv_r;
      A_RX_BAUD: rd_mux = rxdiv_r;
      A_IRQ_STATUS: rd_mux = {5'h00, sts_r};
      A_IRQ_MASK: rd_mux = {5'h00, mask_r};
      default: begin
        rd_mux = RST_BYTE;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !rvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_mux};
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  function automatic logic wr_at(input logic [7:0] a);
    wr_at = wr_go && wlane_r && (awaddr_r == a);
  endfunction

  // mode and control bits; the top bit lands on mode bit 0 only with checking off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {md0_r, md1_r, mpe_r, ren_r, tb8_r} <= 5'h00;
    end else if (wr_at(A_SERIAL_CONTROL)) begin
      if (!fce_r) begin
        md0_r <= wdata_r[SC_TOP];
      end
      md1_r <= wdata_r[SC_MODE1];
      mpe_r <= wdata_r[SC_MPE];
      ren_r <= wdata_r[SC_RXEN];
      tb8_r <= wdata_r[SC_TB8];
    end
  end

  // framing flag: hardware set beats a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      er_r <= 1'b0;
    end else if (er_set) begin
      er_r <= 1'b1;
    end else if (wr_at(A_SERIAL_CONTROL) && fce_r) begin
      er_r <= wdata_r[SC_TOP];
    end
  end

  // done flags follow the same set-over-clear order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_r <= 1'b0;
      ti_r <= 1'b0;
    end else begin
      if (rx_load) begin
        rc_r <= 1'b1;
      end else if (wr_at(A_SERIAL_CONTROL)) begin
        rc_r <= wdata_r[SC_RC];
      end
      if (tx_done) begin
        ti_r <= 1'b1;
      end else if (wr_at(A_SERIAL_CONTROL)) begin
        ti_r <= wdata_r[SC_TI];
      end
    end
  end

  // plain byte registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fce_r <= 1'b0;
      sadr_r <= RST_BYTE;
      smask_r <= RST_BYTE;
      txdiv_r <= RST_BAUD;
      rxdiv_r <= RST_BAUD;
      mask_r <= '0;
    end else begin
      if (wr_at(A_POWER_CONTROL)) fce_r <= wdata_r[PC_FCE];
      if (wr_at(A_SLAVE_ADDRESS)) sadr_r <= wdata_r;
      if (wr_at(A_SLAVE_ADDRESS_MASK)) smask_r <= wdata_r;
      if (wr_at(A_TX_BAUD)) txdiv_r <= wdata_r;
      if (wr_at(A_RX_BAUD)) rxdiv_r <= wdata_r;
      if (wr_at(A_IRQ_MASK)) mask_r <= wdata_r[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  // sticky events, write one to clear; a new event in the clear cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_r <= '0;
      irq_r <= 1'b0;
    end else begin
      sts_r <= (sts_r & ~(wr_at(A_IRQ_STATUS) ? wdata_r[IRQ_W-1:0] : '0))
               | {er_set, tx_done, rx_load};
      irq_r <= |(sts_r & mask_r);
    end
  end

  assign irq = irq_r;

  // ----------------------------------------------------------------
  // baud dividers, one per direction
  // ----------------------------------------------------------------
  // separate dividers let both directions run at once, at unlike rates except in mode 2
  assign rx_div = (mode == MODE_9FIX) ? MODE2_DIV : rxdiv_r;
  assign tx_div = (mode == MODE_9FIX) ? MODE2_DIV : txdiv_r;

  ufa_baud_tick u_rx_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(rx_st_r != S_IDLE),
    .reload(rx_div),
    .tick(rx_tick)
  );

  ufa_baud_tick u_tx_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(tx_st_r != S_IDLE),
    .reload(tx_div),
    .tick(tx_tick)
  );

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  // pin synchroniser; idle line is high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_meta_r <= 1'b1;
      rxd_r <= 1'b1;
    end else begin
      rxd_meta_r <= rxd_pin;
      rxd_r <= rxd_meta_r;
    end
  end

  assign rx_last_bit = nine ? BITS9_LAST : BITS8_LAST;
  assign rx_sh_nxt = {rxd_r, rx_sh_r[8:1]};
  assign rx_mid_done = rx_tick && (rx_ovs_r == OVS_LAST);

  // receive sequencer; 16 ticks per bit, samples near bit centre
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_r <= S_IDLE;
      rx_ovs_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 9'h000;
    end else begin
      if (rx_tick) rx_ovs_r <= rx_ovs_r + 4'h1;
      unique case (rx_st_r)
        S_IDLE: begin
          rx_ovs_r <= 4'h0;
          rx_bit_r <= 4'h0;
          if (ren_r && mode == MODE_SHIFT && !rc_r) begin
            rx_st_r <= S_DATA;
          end else if (ren_r && mode != MODE_SHIFT && !rxd_r) begin
            rx_st_r <= S_START;
          end
        end
        S_START: begin
          if (rx_tick && rx_ovs_r == OVS_MID) begin
            rx_ovs_r <= 4'h0;
            rx_st_r <= rxd_r ? S_IDLE : S_DATA; // glitch rejected
          end
        end
        S_DATA: begin
          if (rx_mid_done) begin
            rx_sh_r <= rx_sh_nxt;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == rx_last_bit) begin
              rx_st_r <= (mode == MODE_SHIFT) ? S_IDLE : S_STOP;
            end
          end
        end
        S_STOP: begin
          if (rx_mid_done) rx_st_r <= S_IDLE;
        end
      endcase
    end
  end

  // decision point: stop sample when checking, or always in mode 1
  assign late_mode = (fce_r || mode == MODE_8BIT) && mode != MODE_SHIFT;
  assign rx_early = (rx_st_r == S_DATA) && rx_mid_done && (rx_bit_r == rx_last_bit);
  assign rx_late = (rx_st_r == S_STOP) && rx_mid_done;
  assign rx_decide = late_mode ? rx_late : rx_early;
  assign rx_src = rx_late ? rx_sh_r : rx_sh_nxt;
  assign rx_word = nine ? rx_src[7:0] : rx_src[8:1];
  // mode 1 has no ninth bit, the stop level marks a command frame
  assign rx_cmd = (mode == MODE_8BIT) ? rxd_r : rx_src[8];

  // given match under mask, or broadcast match on address OR mask
  assign addr_hit = (((rx_word ^ sadr_r) & smask_r) == 8'h00)
                 || (((~rx_word) & (sadr_r | smask_r)) == 8'h00);

  // filtering is hardware only and ignored in mode 0; mode 1 also needs a good stop
  assign rx_load = rx_decide && !rc_r
                && (mode == MODE_SHIFT || !mpe_r || (rx_cmd && addr_hit));

  // stop level checked at its sample point
  assign er_set = rx_late && fce_r && !rxd_r;

  // receive buffer and ninth bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxbuf_r <= RST_BYTE;
      rb8_r <= 1'b0;
    end else if (rx_load) begin
      rxbuf_r <= rx_word;
      if (mode != MODE_SHIFT) rb8_r <= rx_cmd;
    end
  end

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  // a write while busy is dropped; software paces on the done flag
  assign tx_go = wr_at(A_SERIAL_DATA) && (tx_st_r == S_IDLE);
  assign tx_last_bit = (mode == MODE_SHIFT) ? TX0_LAST
                     : (nine ? TX2_LAST : TX1_LAST);
  assign tx_done = (tx_st_r == S_DATA) && tx_tick
                && (tx_ovs_r == OVS_LAST) && (tx_bit_r == tx_last_bit);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_r <= S_IDLE;
      tx_ovs_r <= 4'h0;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 11'h7FF;
    end else if (tx_go) begin
      tx_st_r <= S_DATA;
      tx_ovs_r <= 4'h0;
      tx_bit_r <= 4'h0;
      if (mode == MODE_SHIFT) begin
        tx_sh_r <= {3'h7, wdata_r};
      end else begin
        tx_sh_r <= {1'b1, nine ? tb8_r : 1'b1, wdata_r, 1'b0};
      end
    end else if (tx_st_r == S_DATA && tx_tick) begin
      tx_ovs_r <= tx_ovs_r + 4'h1;
      if (tx_ovs_r == OVS_LAST) begin
        tx_sh_r <= {1'b1, tx_sh_r[10:1]};
        tx_bit_r <= tx_bit_r + 4'h1;
        if (tx_done) tx_st_r <= S_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // line outputs
  // ----------------------------------------------------------------
  // shift clock is low in the first half of each mode 0 bit, rising mid-bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_r <= 1'b1;
      sclk_r <= 1'b1;
    end else begin
      txd_r <= (tx_st_r == S_DATA) ? tx_sh_r[0] : 1'b1;
      sclk_r <= !(mode == MODE_SHIFT
                  && ((tx_st_r == S_DATA && !tx_ovs_r[3])
                      || (rx_st_r == S_DATA && !rx_ovs_r[3])));
    end
  end

  assign txd_pin = txd_r;
  assign shift_clk_pin = sclk_r;

endmodule

`default_nettype wire

// >>> verification/ufa_serial_port_properties.sv
// bus handshake and line idle checks for the serial port, bound to its top module
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module ufa_serial_port_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // line and interrupt
  input wire logic txd_pin,
  input wire logic shift_clk_pin,
  input wire logic irq
);
  import ufa_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a pending answer must block new requests, else one would be lost
  write_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write request open while answer pending");
  read_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read request open while answer pending");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  read_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  // unmapped reads return zero data, mapped ones only a byte
  read_code_a: assert property (s_axi_rvalid |->
      (s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h0) ||
      (s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)) else $error("bad read answer");
  reset_idle_a: assert property ($rose(aresetn) |-> !irq && txd_pin && shift_clk_pin)
    else $error("outputs not idle after reset");
endmodule
bind ufa_serial_port ufa_serial_port_props i_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .txd_pin, .shift_clk_pin, .irq);
`default_nettype wire

// >>> verification/ufa_node_model.sv
// far serial node: sends frames on the receive line, takes bytes off the transmit line
// assumes the bench set the dividers so that a bit lasts the given number of cycles
`timescale 1ns/1ps
`default_nettype none
module ufa_node_model (
  // clock
  input wire logic aclk,
  // line
  output logic rxd_pin,
  input wire logic txd_pin,
  // high while the stop bit is on the line
  output logic stop_phase
);
  // the receive line starts idle high, driven by the model
  initial begin
    rxd_pin = 1'b1;
    stop_phase = 1'b0;
  end
  // start, data lsb first, ninth bit unless nine is low (mode 1), stop
  task automatic send(input logic [7:0] d, input logic b9, nine, stp, input int bl);
    logic [10:0] f;
    int n;
    f = {stp, b9, d, 1'b0};
    n = nine ? 11 : 10;
    if (!nine) f[9] = stp;
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      rxd_pin <= f[i];
      stop_phase <= (i == n - 1);
      repeat (bl - 1) @(posedge aclk);
    end
    @(posedge aclk);
    rxd_pin <= 1'b1;
    stop_phase <= 1'b0;
  endtask
  // mid-bit sampling keeps clear of the edges of a 16-cycle bit
  task automatic take(output logic [7:0] d);
    wait (txd_pin === 1'b0);
    repeat (8) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge aclk);
      d[i] = txd_pin;
    end
  endtask
endmodule
`default_nettype wire

// >>> verification/ufa_serial_port_tb.sv
// self-checking bench for the serial port: register bus tasks, frames and flag checks
// assumes the node model on the serial line and the bound property checker
`timescale 1ns/1ps
`default_nettype none
module ufa_serial_port_tb;
  import ufa_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic rxd_pin, txd_pin, shift_clk_pin, irq, stop_phase;
  logic [7:0] rx_b;
  int error_cnt = 0, checks = 0;
  // frame table: control value, byte, {ninth bit, stop level, done expected}
  logic [7:0] ctl [11] = '{8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'h70, 8'h70, 8'h70,
    8'h30, 8'hB0};
  logic [7:0] dat [11] = '{8'h55, 8'h57, 8'h66, 8'hFE, 8'hDA, 8'h55, 8'h55, 8'h55, 8'h66,
    8'hFF, 8'h54};
  logic [2:0] flg [11] = '{3'b111, 3'b111, 3'b110, 3'b111, 3'b110, 3'b010, 3'b111, 3'b100,
    3'b110, 3'b111, 3'b111};

  ufa_serial_port i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .rxd_pin, .txd_pin, .shift_clk_pin, .irq);
  ufa_node_model i_node (.aclk, .rxd_pin, .txd_pin, .stop_phase);

  always #50 aclk = ~aclk;

  task automatic chk(input logic [33:0] got, exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk({r, d & m}, {er, e});
  endtask
  // mode 0 needs no frame: it shifts in the idle-high line once enabled
  task automatic frame(input logic [7:0] c, d, input logic [2:0] f);
    wr(A_SERIAL_CONTROL, {24'h0, c});
    if (c[7:6] == 2'h0) begin
      repeat (4) @(posedge aclk);
      chk({33'h0, shift_clk_pin}, 34'h0);
      repeat (196) @(posedge aclk);
    end else i_node.send(d, f[2], c[7:6] != 2'h1, f[1], (c[7:6] == 2'h2) ? 512 : 16);
    repeat (6) @(posedge aclk);
    rd_chk(A_SERIAL_CONTROL, 32'h1, {31'h0, f[0]}, RESP_OKAY);
    if (f[0]) rd_chk(A_SERIAL_DATA, 32'hFF, {24'h0, d}, RESP_OKAY);
  endtask
  task automatic conclude;
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(A_SLAVE_ADDRESS, 32'hFF, 32'h0, RESP_OKAY);
    rd_chk(A_SLAVE_ADDRESS_MASK, 32'hFF, 32'h0, RESP_OKAY);
    rd_chk(8'hFC, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    wr(A_RX_BAUD, 32'h0);
    wr(A_TX_BAUD, 32'h0);
    wr(A_IRQ_MASK, 32'h1);
    frame(8'hF0, 8'h66, 3'b111);
    wr(A_SLAVE_ADDRESS, 32'h56);
    wr(A_SLAVE_ADDRESS_MASK, 32'hFC);
    for (int i = 0; i < 11; i++) frame(ctl[i], dat[i], flg[i]);
    // a bad stop with checking off leaves the flag clear; later it sets and sticks
    wr(A_SERIAL_CONTROL, 32'h50);
    i_node.send(8'h3C, 1'b0, 1'b0, 1'b0, 16);
    wr(A_POWER_CONTROL, 32'h40);
    rd_chk(A_SERIAL_CONTROL, 32'h80, 32'h0, RESP_OKAY);
    wr(A_SERIAL_CONTROL, 32'h50);
    i_node.send(8'h3C, 1'b0, 1'b0, 1'b0, 16);
    rd_chk(A_SERIAL_CONTROL, 32'h80, 32'h80, RESP_OKAY);
    i_node.send(8'h3C, 1'b0, 1'b0, 1'b1, 16);
    rd_chk(A_SERIAL_CONTROL, 32'h80, 32'h80, RESP_OKAY);
    wr(A_SERIAL_CONTROL, 32'h50);
    rd_chk(A_SERIAL_CONTROL, 32'hC0, 32'h40, RESP_OKAY);
    wr(A_POWER_CONTROL, 32'h0);
    wr(A_SERIAL_CONTROL, 32'hD0);
    rd_chk(A_SERIAL_CONTROL, 32'hC0, 32'hC0, RESP_OKAY);
    wr(A_POWER_CONTROL, 32'h40);
    rd_chk(A_SERIAL_CONTROL, 32'h80, 32'h0, RESP_OKAY);
    // mode 3 with checking on: done must wait for the stop sample
    fork
      i_node.send(8'h11, 1'b1, 1'b1, 1'b1, 16);
      begin
        @(posedge stop_phase);
        rd_chk(A_SERIAL_CONTROL, 32'h1, 32'h0, RESP_OKAY);
      end
    join
    repeat (6) @(posedge aclk);
    rd_chk(A_SERIAL_CONTROL, 32'h1, 32'h1, RESP_OKAY);
    // both directions at once
    wr(A_POWER_CONTROL, 32'h0);
    wr(A_SERIAL_CONTROL, 32'h50);
    fork
      i_node.take(rx_b);
      i_node.send(8'h5A, 1'b0, 1'b0, 1'b1, 16);
      wr(A_SERIAL_DATA, 32'hC3);
    join
    repeat (40) @(posedge aclk);
    chk({26'h0, rx_b}, 34'hC3);
    rd_chk(A_SERIAL_DATA, 32'hFF, 32'h5A, RESP_OKAY);
    chk({33'h0, irq}, 34'h1);
    wr(A_IRQ_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    chk({33'h0, irq}, 34'h0);
    wr(A_IRQ_STATUS, 32'h7);
    rd_chk(A_IRQ_STATUS, 32'h7, 32'h0, RESP_OKAY);
    wr(A_IRQ_MASK, 32'h7);
    repeat (2) @(posedge aclk);
    chk({33'h0, irq}, 34'h0);
    conclude();
  end
  // the mode 2 frame dominates at about 6000 cycles; the whole run is far below this
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
